// ### src/cdm_regs.svh
// Purpose: Offsets, field positions, reset values and cycle counts
// Assumes: Included by the data-move core and its package users
// Notes: Byte addresses on a 32-bit AHB-Lite slave
`ifndef CDM_REGS_SVH
`define CDM_REGS_SVH

`define CDM_A_CMD 8'h00
`define CDM_A_KADR 8'h04
`define CDM_A_STAT 8'h08
`define CDM_A_FLAG 8'h0c
`define CDM_A_SP 8'h10
`define CDM_GPR_BIT 7

`define CDM_F_OP 4:0
`define CDM_F_REG 9:5
`define CDM_F_Q 15:10
`define CDM_F_BIT 18:16
`define CDM_F_IO 23:19
`define CDM_F_PSEL 25:24
`define CDM_F_MODE 27:26

`define CDM_FC 0
`define CDM_FZ 1
`define CDM_FN 2
`define CDM_FV 3
`define CDM_FS 4
`define CDM_FT 6

`define CDM_MODE_POST 2'h1
`define CDM_MODE_PRE 2'h2
`define CDM_PSEL_Y 2'h1
`define CDM_PSEL_Z 2'h2
`define CDM_PTR_BASE 5'h1a

`define CDM_CYC_ONE 2'h1
`define CDM_CYC_MEM 2'h2
`define CDM_CYC_PM 2'h3

`define CDM_SP_RST 16'h01ff
`define CDM_FLAG_RST 8'h00

`endif

// ### src/cdm_pkg.sv
// Purpose: Types of the data-move and bit-operation core
// Assumes: Nothing
// Notes: Operation codes sit in the low five bits of the command word
package cdm_pkg;

	typedef enum logic [4:0] {
		CDM_NOP = 5'h00,
		CDM_PLOAD = 5'h01,
		CDM_DLOAD = 5'h02,
		CDM_ALOAD = 5'h03,
		CDM_PSTORE = 5'h04,
		CDM_DSTORE = 5'h05,
		CDM_ASTORE = 5'h06,
		CDM_PMREAD = 5'h07,
		CDM_PUSH = 5'h08,
		CDM_POP = 5'h09,
		CDM_IOSET = 5'h0a,
		CDM_IOCLR = 5'h0b,
		CDM_ROTL = 5'h0c,
		CDM_ROTR = 5'h0d,
		CDM_TSAVE = 5'h0e,
		CDM_TPUT = 5'h0f,
		CDM_VSET = 5'h10,
		CDM_VCLR = 5'h11,
		CDM_SSET = 5'h12,
		CDM_SCLR = 5'h13
	} cdm_op_t;

	typedef enum logic [1:0] {
		CDM_IDLE = 2'b00,
		CDM_RUN = 2'b01
	} cdm_state_t;

endpackage

// ### src/cdm_core.sv
// Purpose: Executes data-move, stack, I/O-bit, rotate and flag commands
// Assumes: AHB-Lite master issues commands; sync data and program memory
// Notes: I/O read data is valid in the same cycle as io_re
// Operation
// RULE_01: Displaced load reads pointer plus q, two cycles
// RULE_02: Post-increment load reads then bumps pointer
// RULE_03: Pre-decrement load drops pointer then reads
// RULE_04: Direct load reads absolute address, two cycles
// RULE_05: Post-increment store writes then bumps pointer
// RULE_06: Pre-decrement store drops pointer then writes
// RULE_07: Displaced store writes pointer plus q, pointer kept
// RULE_08: Direct store writes absolute address, flags kept
// RULE_09: Program read via Z, three cycles, optional increment
// RULE_10: Push stores register on stack, two cycles
// RULE_11: Pop loads top stack byte, two cycles
// RULE_12: I/O bit set in two cycles
// RULE_13: I/O bit clear in two cycles
// RULE_14: Rotate left through carry, updating five flags
// RULE_15: Rotate right through carry, updating five flags
// RULE_16: Copy register bit into transfer flag
// RULE_17: Copy transfer flag into register bit
// RULE_18: Set or clear overflow flag only
// RULE_19: Set or clear signed flag only
// RULE_20: Pointers are fixed register pairs, carry across
`include "cdm_regs.svh"

module cdm_core import cdm_pkg::*; #(
	parameter logic [15:0] SP_RST = `CDM_SP_RST
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [15:0] dm_addr,
	output logic [7:0] dm_wdata,
	output logic dm_we,
	output logic dm_re,
	input wire logic [7:0] dm_rdata,
	output logic [4:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	input wire logic [7:0] io_rdata,
	output logic [14:0] pm_addr,
	output logic pm_re,
	input wire logic [15:0] pm_rdata
);

	function automatic logic [1:0] op_cycles(input cdm_op_t op);
		case (op)
			CDM_PMREAD: op_cycles = `CDM_CYC_PM;
			CDM_PLOAD, CDM_DLOAD, CDM_ALOAD, CDM_PSTORE, CDM_DSTORE,
			CDM_ASTORE, CDM_PUSH, CDM_POP, CDM_IOSET, CDM_IOCLR:
				op_cycles = `CDM_CYC_MEM;
			default: op_cycles = `CDM_CYC_ONE;
		endcase
	endfunction

	function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
		ptr_lo = `CDM_PTR_BASE + {2'h0, sel, 1'b0};
	endfunction

	logic [7:0] gpr_ff [32];
	cdm_state_t state_ff;
	logic [1:0] cnt_ff, psel_ff;
	logic [31:0] cmd_ff, hrdata_ff;
	logic [15:0] kadr_ff, sp_ff, ptr_ff, dm_addr_ff;
	logic [7:0] flags_ff, pmb_ff, wa_ff, dm_wdata_ff, io_wdata_ff;
	logic [4:0] io_addr_ff;
	logic [14:0] pm_addr_ff;
	logic aph_ff, wr_ff, hreadyout_ff, hresp_ff, first_ff;
	logic dm_we_ff, dm_re_ff, io_we_ff, io_re_ff, pm_re_ff;
	logic idle, bus_wr, issue, last, ptr_upd, rot_c;
	cdm_op_t op, n_op;
	logic [4:0] rd, n_reg;
	logic [2:0] bsel;
	logic [1:0] mode, n_psel, n_mode;
	logic [15:0] n_ptr, nxt_addr, ptr_new;
	logic [7:0] rot_src, rot_res;
	logic [31:0] nxt_hrdata;
	assign idle = state_ff == CDM_IDLE;
	assign bus_wr = aph_ff && wr_ff;
	assign issue = idle && bus_wr && wa_ff == `CDM_A_CMD;
	assign last = state_ff == CDM_RUN && cnt_ff == 2'h1;
	assign op = cdm_op_t'(cmd_ff[`CDM_F_OP]);
	assign rd = cmd_ff[`CDM_F_REG];
	assign bsel = cmd_ff[`CDM_F_BIT];
	assign mode = cmd_ff[`CDM_F_MODE];
	assign n_op = cdm_op_t'(hwdata[`CDM_F_OP]);
	assign n_reg = hwdata[`CDM_F_REG];
	assign n_mode = hwdata[`CDM_F_MODE];

	// Displaced and program reads only reach Y or Z
	always_comb begin
		n_psel = hwdata[`CDM_F_PSEL];
		if (n_op == CDM_PMREAD)
			n_psel = `CDM_PSEL_Z;
		else if ((n_op == CDM_DLOAD || n_op == CDM_DSTORE) && n_psel != `CDM_PSEL_Y)
			n_psel = `CDM_PSEL_Z;
	end

	assign n_ptr = {gpr_ff[ptr_lo(n_psel) + 5'h01], gpr_ff[ptr_lo(n_psel)]}; // RULE_20
	always_comb begin
		nxt_addr = n_ptr;
		case (n_op)
			CDM_PLOAD, CDM_PSTORE: begin
				if (n_mode == `CDM_MODE_PRE)
					nxt_addr = n_ptr - 16'h0001; // RULE_03 RULE_06
			end
			CDM_DLOAD, CDM_DSTORE:
				nxt_addr = n_ptr + {10'h000, hwdata[`CDM_F_Q]}; // RULE_01 RULE_07
			CDM_ALOAD, CDM_ASTORE:
				nxt_addr = kadr_ff; // RULE_04 RULE_08
			CDM_PUSH:
				nxt_addr = sp_ff; // RULE_10
			CDM_POP:
				nxt_addr = sp_ff + 16'h0001; // RULE_11
			default: ;
		endcase
	end
	// Pointer write-back after the access
	always_comb begin
		ptr_upd = 1'b0;
		ptr_new = ptr_ff + 16'h0001; // RULE_02 RULE_05
		if (op == CDM_PLOAD || op == CDM_PSTORE) begin
			ptr_upd = mode == `CDM_MODE_POST || mode == `CDM_MODE_PRE;
			if (mode == `CDM_MODE_PRE)
				ptr_new = ptr_ff - 16'h0001; // RULE_03 RULE_06
		end else if (op == CDM_PMREAD)
			ptr_upd = mode == `CDM_MODE_PRE; // RULE_09
	end
	always_comb begin
		rot_src = gpr_ff[rd];
		if (op == CDM_ROTL) begin
			rot_res = {rot_src[6:0], flags_ff[`CDM_FC]}; // RULE_14
			rot_c = rot_src[7];
		end else begin
			rot_res = {flags_ff[`CDM_FC], rot_src[7:1]}; // RULE_15
			rot_c = rot_src[0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= CDM_IDLE;
			cnt_ff <= 2'h0;
		end else begin
			case (state_ff)
				CDM_IDLE: begin
					if (issue) begin
						state_ff <= CDM_RUN;
						cnt_ff <= op_cycles(n_op);
					end
				end
				CDM_RUN: begin
					cnt_ff <= cnt_ff - 2'h1;
					if (cnt_ff == 2'h1)
						state_ff <= CDM_IDLE;
				end
				default: state_ff <= CDM_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_ff <= 32'h0000_0000;
			ptr_ff <= 16'h0000;
			psel_ff <= 2'h0;
			first_ff <= 1'b0;
		end else begin
			first_ff <= issue;
			if (issue) begin
				cmd_ff <= hwdata;
				ptr_ff <= n_ptr;
				psel_ff <= n_psel;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dm_addr_ff <= 16'h0000;
			dm_wdata_ff <= 8'h00;
			dm_re_ff <= 1'b0;
			dm_we_ff <= 1'b0;
		end else begin
			dm_re_ff <= 1'b0;
			dm_we_ff <= 1'b0;
			if (issue) begin
				dm_addr_ff <= nxt_addr;
				dm_wdata_ff <= gpr_ff[n_reg];
				dm_re_ff <= n_op inside {CDM_PLOAD, CDM_DLOAD, CDM_ALOAD, CDM_POP};
				dm_we_ff <= n_op inside {CDM_PSTORE, CDM_DSTORE, CDM_ASTORE, CDM_PUSH};
			end
		end
	end

	// Read-modify-write of one I/O bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_addr_ff <= 5'h00;
			io_wdata_ff <= 8'h00;
			io_re_ff <= 1'b0;
			io_we_ff <= 1'b0;
		end else begin
			io_re_ff <= 1'b0;
			io_we_ff <= 1'b0;
			if (issue) begin
				io_addr_ff <= hwdata[`CDM_F_IO];
				io_re_ff <= n_op == CDM_IOSET || n_op == CDM_IOCLR;
			end
			if (io_re_ff) begin
				io_we_ff <= 1'b1;
				if (op == CDM_IOSET)
					io_wdata_ff <= io_rdata | (8'h01 << bsel); // RULE_12
				else
					io_wdata_ff <= io_rdata & ~(8'h01 << bsel); // RULE_13
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pm_addr_ff <= 15'h0000;
			pm_re_ff <= 1'b0;
			pmb_ff <= 8'h00;
		end else begin
			pm_re_ff <= issue && n_op == CDM_PMREAD;
			if (issue)
				pm_addr_ff <= n_ptr[15:1];
			if (state_ff == CDM_RUN && op == CDM_PMREAD && cnt_ff == 2'h2)
				pmb_ff <= ptr_ff[0] ? pm_rdata[15:8] : pm_rdata[7:0]; // RULE_09
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++)
				gpr_ff[i] <= 8'h00;
		end else begin
			if (idle && bus_wr && wa_ff[`CDM_GPR_BIT])
				gpr_ff[wa_ff[6:2]] <= hwdata[7:0];
			if (last) begin
				case (op)
					CDM_PLOAD, CDM_DLOAD, CDM_ALOAD, CDM_POP:
						gpr_ff[rd] <= dm_rdata; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_11
					CDM_PMREAD:
						gpr_ff[mode == 2'h0 ? 5'h00 : rd] <= pmb_ff; // RULE_09
					CDM_ROTL, CDM_ROTR:
						gpr_ff[rd] <= rot_res; // RULE_14 RULE_15
					CDM_TPUT:
						gpr_ff[rd][bsel] <= flags_ff[`CDM_FT]; // RULE_17
					default: ;
				endcase
				if (ptr_upd)
					{gpr_ff[ptr_lo(psel_ff) + 5'h01], gpr_ff[ptr_lo(psel_ff)]} <= ptr_new; // RULE_20
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_ff <= `CDM_FLAG_RST;
		end else if (idle && bus_wr && wa_ff == `CDM_A_FLAG) begin
			flags_ff <= hwdata[7:0];
		end else if (last) begin
			case (op)
				CDM_ROTL, CDM_ROTR: begin
					flags_ff[`CDM_FC] <= rot_c; // RULE_14 RULE_15
					flags_ff[`CDM_FZ] <= rot_res == 8'h00;
					flags_ff[`CDM_FN] <= rot_res[7];
					flags_ff[`CDM_FV] <= rot_res[7] ^ rot_c;
					flags_ff[`CDM_FS] <= rot_c;
				end
				CDM_TSAVE: flags_ff[`CDM_FT] <= rot_src[bsel]; // RULE_16
				CDM_VSET: flags_ff[`CDM_FV] <= 1'b1; // RULE_18
				CDM_VCLR: flags_ff[`CDM_FV] <= 1'b0; // RULE_18
				CDM_SSET: flags_ff[`CDM_FS] <= 1'b1; // RULE_19
				CDM_SCLR: flags_ff[`CDM_FS] <= 1'b0; // RULE_19
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sp_ff <= SP_RST;
			kadr_ff <= 16'h0000;
		end else begin
			if (idle && bus_wr && wa_ff == `CDM_A_SP)
				sp_ff <= hwdata[15:0];
			else if (last && op == CDM_PUSH)
				sp_ff <= sp_ff - 16'h0001; // RULE_10
			else if (last && op == CDM_POP)
				sp_ff <= sp_ff + 16'h0001; // RULE_11
			if (idle && bus_wr && wa_ff == `CDM_A_KADR)
				kadr_ff <= hwdata[15:0];
		end
	end

	always_comb begin
		if (haddr[`CDM_GPR_BIT])
			nxt_hrdata = {24'h000000, gpr_ff[haddr[6:2]]};
		else
			case (haddr[7:0])
				`CDM_A_CMD: nxt_hrdata = cmd_ff;
				`CDM_A_KADR: nxt_hrdata = {16'h0000, kadr_ff};
				`CDM_A_STAT: nxt_hrdata = {sp_ff, flags_ff, 7'h00, !idle};
				`CDM_A_FLAG: nxt_hrdata = {24'h000000, flags_ff};
				`CDM_A_SP: nxt_hrdata = {16'h0000, sp_ff};
				default: nxt_hrdata = 32'h0000_0000;
			endcase
	end

	// Zero-wait slave: read data stands in the data phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aph_ff <= 1'b0;
			wr_ff <= 1'b0;
			wa_ff <= 8'h00;
			hrdata_ff <= 32'h0000_0000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			if (hready) begin
				aph_ff <= hsel && htrans[1];
				wr_ff <= hwrite;
				wa_ff <= haddr[7:0];
				if (hsel && htrans[1] && !hwrite)
					hrdata_ff <= nxt_hrdata;
			end
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign hresp = hresp_ff;
	assign dm_addr = dm_addr_ff;
	assign dm_wdata = dm_wdata_ff;
	assign dm_we = dm_we_ff;
	assign dm_re = dm_re_ff;
	assign io_addr = io_addr_ff;
	assign io_wdata = io_wdata_ff;
	assign io_we = io_we_ff;
	assign io_re = io_re_ff;
	assign pm_addr = pm_addr_ff;
	assign pm_re = pm_re_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_disp_load_addr: assert property ( // RULE_01
		first_ff && op == CDM_DLOAD |-> dm_re_ff && dm_addr_ff == ptr_ff + {10'h000, cmd_ff[`CDM_F_Q]}
	) else $error("displaced load address wrong");
	chk_postinc_load: assert property ( // RULE_02
		first_ff && op == CDM_PLOAD && mode == `CDM_MODE_POST
		|-> dm_addr_ff == ptr_ff ##1 last ##1 idle
	) else $error("post-increment load timing wrong");
	chk_predec_addr: assert property ( // RULE_03
		first_ff && op == CDM_PLOAD && mode == `CDM_MODE_PRE |-> dm_addr_ff == ptr_ff - 16'h0001
	) else $error("pre-decrement address wrong");
	chk_direct_flags: assert property ( // RULE_04
		first_ff && op == CDM_ALOAD |-> dm_addr_ff == kadr_ff ##2 $stable(flags_ff)
	) else $error("direct load changed flags");
	chk_store_data: assert property ( // RULE_05
		first_ff && op == CDM_PSTORE |-> dm_we_ff && dm_wdata_ff == gpr_ff[rd]
	) else $error("store data missing");
	chk_pmread_len: assert property ( // RULE_09
		issue && n_op == CDM_PMREAD |=> (state_ff == CDM_RUN)[*3] ##1 idle
	) else $error("program read not three cycles");
	chk_push_sp: assert property ( // RULE_10
		last && op == CDM_PUSH |=> sp_ff == $past(sp_ff) - 16'h0001
	) else $error("push did not drop stack pointer");
	chk_ioset_bit: assert property ( // RULE_12
		io_we_ff && op == CDM_IOSET |-> io_wdata_ff[bsel] && $past(io_re_ff)
	) else $error("I/O bit set wrong");
	chk_rotl_carry: assert property ( // RULE_14
		last && op == CDM_ROTL |=> flags_ff[`CDM_FC] == $past(rot_src[7])
	) else $error("rotate left carry wrong");
	chk_tflag_copy: assert property ( // RULE_16
		last && op == CDM_TSAVE |=> flags_ff[`CDM_FT] == $past(rot_src[bsel])
	) else $error("transfer flag copy wrong");
	chk_vset_only: assert property ( // RULE_18
		last && op == CDM_VSET |=> flags_ff[`CDM_FV] && flags_ff[2:0] == $past(flags_ff[2:0])
	) else $error("overflow set disturbed flags");
	cov_pop: cover property (last && op == CDM_POP);
	cov_disp_store: cover property (last && op == CDM_DSTORE);
	cov_io_clear: cover property (io_we_ff && op == CDM_IOCLR);

endmodule // cdm_core

// ### verif/cdm_mem_model.sv
// Purpose: Data memory, I/O space and program memory beside the core
// Assumes: Sync data and program reads, combinational I/O read
// Notes: Data and program reads show inverted stale data outside their valid cycle; I/O reads inverted data without io_re
module cdm_mem_model (
	input wire logic clk,
	input wire logic [15:0] dm_addr,
	input wire logic [7:0] dm_wdata,
	input wire logic dm_we,
	input wire logic dm_re,
	output logic [7:0] dm_rdata,
	input wire logic [4:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	output logic [7:0] io_rdata,
	input wire logic [14:0] pm_addr,
	input wire logic pm_re,
	output logic [15:0] pm_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] dmem [512];
	logic [7:0] iom [32];
	logic [15:0] pmem [256];
	logic [7:0] dq;
	logic [15:0] pq;
	logic dv_ff, pv_ff;

	initial begin
		for (int i = 0; i < 512; i++) dmem[i] = 8'(i) ^ 8'h5a;
		for (int i = 0; i < 32; i++) iom[i] = 8'(i);
		for (int i = 0; i < 256; i++) pmem[i] = {8'(i) ^ 8'hc3, 8'(i)};
		dq = 8'h00;
		pq = 16'h0000;
		dv_ff = 1'b0;
		pv_ff = 1'b0;
	end

	always @(posedge clk) begin
		dv_ff <= dm_re;
		pv_ff <= pm_re;
		if (dm_re) dq <= dmem[dm_addr[8:0]];
		if (dm_we) dmem[dm_addr[8:0]] <= dm_wdata;
		if (io_we) iom[io_addr] <= io_wdata;
		if (pm_re) pq <= pmem[pm_addr[7:0]];
	end

	assign dm_rdata = dv_ff ? dq : ~dq;
	assign pm_rdata = pv_ff ? pq : ~pq;
	assign io_rdata = io_re ? iom[io_addr] : ~iom[io_addr];
endmodule // cdm_mem_model

// ### verif/cdm_core_tb.sv
// Purpose: Self-checking bench of the data-move core over AHB-Lite
// Assumes: Zero-wait slave, STATUS bit 0 polled after each command issued by run
// Notes: Memory contents checked inside the partner model
`include "cdm_regs.svh"

module cdm_core_tb import cdm_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic dm_we, dm_re, io_we, io_re, pm_re;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] dm_addr, pm_rdata;
	logic [7:0] dm_wdata, dm_rdata, io_wdata, io_rdata;
	logic [4:0] io_addr;
	logic [14:0] pm_addr;
	int fail_count, cmp_count, cyc;

	assign hready = hreadyout;

	cdm_core cdm_core_i (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata,
		.io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .pm_addr, .pm_re, .pm_rdata);
	cdm_mem_model cdm_mem_model_i (.clk, .dm_addr, .dm_wdata, .dm_we, .dm_re, .dm_rdata,
		.io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .pm_addr, .pm_re, .pm_rdata);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] t;
		bus(1'b1, a, d, t);
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] t;
		bus(1'b0, a, 32'h0, t);
		chk(n, e, t);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
	endtask

	function automatic logic [7:0] gpr(input int i);
		return 8'h80 | 8'(i << 2);
	endfunction

	function automatic logic [31:0] cw(cdm_op_t op, int r, int q, int b, int io, int ps, int md);
		return {4'h0, 2'(md), 2'(ps), 5'(io), 3'(b), 6'(q), 5'(r), op};
	endfunction

	// Issue a command and poll busy to clear
	task automatic run(input logic [31:0] c);
		logic [31:0] s;
		int n;
		wr(`CDM_A_CMD, c);
		n = 0;
		do begin
			bus(1'b0, `CDM_A_STAT, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 20);
		chk("busy", 32'h0, {31'h0, s[0]});
	endtask

	task automatic ptrs(input logic [7:0] v [6]);
		for (int i = 0; i < 6; i++) wr(gpr(26 + i), {24'h0, v[i]});
	endtask

	logic [7:0] fl_exp [4] = '{8'h5d, 8'h4d, 8'h45, 8'h55};
	cdm_op_t fl_op [4] = '{CDM_VSET, CDM_SCLR, CDM_VCLR, CDM_SSET};

	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk("status", `CDM_A_STAT, {16'h01ff, 16'h0000});
		rchk("unmapped", 8'h40, 32'h0);
		wr(`CDM_A_FLAG, 32'h0b);
		ptrs('{8'h10, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00});
		wr(`CDM_A_KADR, 32'h0150);
		run(cw(CDM_PLOAD, 1, 0, 0, 0, 0, 1));
		run(cw(CDM_PLOAD, 2, 0, 0, 0, 1, 2));
		run(cw(CDM_DLOAD, 3, 5, 0, 0, 1, 0));
		run(cw(CDM_ALOAD, 4, 0, 0, 0, 0, 0));
		rchk("r1", gpr(1), 32'h4a);
		rchk("x_lo", gpr(26), 32'h11);
		rchk("r2", gpr(2), 32'ha5);
		rchk("y_lo", gpr(28), 32'hff);
		rchk("y_hi", gpr(29), 32'h00);
		rchk("r3", gpr(3), 32'h5e);
		rchk("r4", gpr(4), 32'h0a);
		rchk("flags_load", `CDM_A_FLAG, 32'h0b);
		run(cw(CDM_PSTORE, 1, 0, 0, 0, 2, 1));
		run(cw(CDM_PSTORE, 2, 0, 0, 0, 0, 2));
		run(cw(CDM_DSTORE, 3, 63, 0, 0, 2, 0));
		wr(`CDM_A_KADR, 32'h01a0);
		run(cw(CDM_ASTORE, 4, 0, 0, 0, 0, 0));
		chk("store_post", 32'h4a, {24'h0, cdm_mem_model_i.dmem[9'h0ff]});
		rchk("z_hi", gpr(31), 32'h01);
		chk("store_pre", 32'ha5, {24'h0, cdm_mem_model_i.dmem[9'h010]});
		rchk("x_lo2", gpr(26), 32'h10);
		chk("store_disp", 32'h5e, {24'h0, cdm_mem_model_i.dmem[9'h13f]});
		rchk("z_lo", gpr(30), 32'h00);
		chk("store_dir", 32'h0a, {24'h0, cdm_mem_model_i.dmem[9'h1a0]});
		rchk("flags_store", `CDM_A_FLAG, 32'h0b);
		ptrs('{8'h10, 8'h00, 8'h00, 8'h01, 8'h43, 8'h00});
		run(cw(CDM_PMREAD, 9, 0, 0, 0, 2, 0));
		run(cw(CDM_PMREAD, 9, 0, 0, 0, 2, 1));
		run(cw(CDM_PMREAD, 10, 0, 0, 0, 2, 2));
		run(cw(CDM_PMREAD, 11, 0, 0, 0, 2, 2));
		rchk("pm_r0", gpr(0), 32'he2);
		rchk("pm_r9", gpr(9), 32'he2);
		rchk("pm_r10", gpr(10), 32'he2);
		rchk("pm_r11", gpr(11), 32'h22);
		rchk("pm_z", gpr(30), 32'h45);
		run(cw(CDM_PLOAD, 13, 0, 0, 0, 2, 0));
		rchk("plain_load", gpr(13), 32'h1f);
		rchk("z_kept", gpr(30), 32'h45);
		run(cw(CDM_PSTORE, 13, 0, 0, 0, 1, 0));
		chk("plain_store", 32'h1f, {24'h0, cdm_mem_model_i.dmem[9'h100]});
		rchk("y_kept", gpr(28), 32'h00);
		run(cw(CDM_PUSH, 4, 0, 0, 0, 0, 0));
		chk("push", 32'h0a, {24'h0, cdm_mem_model_i.dmem[9'h1ff]});
		rchk("sp_push", `CDM_A_SP, 32'h01fe);
		run(cw(CDM_POP, 12, 0, 0, 0, 0, 0));
		rchk("pop", gpr(12), 32'h0a);
		rchk("sp_pop", `CDM_A_SP, 32'h01ff);
		run(cw(CDM_IOSET, 0, 0, 7, 31, 0, 0));
		chk("io_set", 32'h9f, {24'h0, cdm_mem_model_i.iom[31]});
		run(cw(CDM_IOCLR, 0, 0, 0, 31, 0, 0));
		chk("io_clr", 32'h9e, {24'h0, cdm_mem_model_i.iom[31]});
		rchk("flags_io", `CDM_A_FLAG, 32'h0b);
		wr(gpr(7), 32'h81);
		run(cw(CDM_ROTL, 7, 0, 0, 0, 0, 0));
		rchk("rotl", gpr(7), 32'h03);
		rchk("rotl_fl", `CDM_A_FLAG, 32'h19);
		run(cw(CDM_ROTR, 7, 0, 0, 0, 0, 0));
		rchk("rotr", gpr(7), 32'h81);
		rchk("rotr_fl", `CDM_A_FLAG, 32'h15);
		run(cw(CDM_TSAVE, 7, 0, 7, 0, 0, 0));
		rchk("t_fl", `CDM_A_FLAG, 32'h55);
		wr(gpr(8), 32'h00);
		run(cw(CDM_TPUT, 8, 0, 3, 0, 0, 0));
		rchk("t_bit", gpr(8), 32'h08);
		rchk("t_fl2", `CDM_A_FLAG, 32'h55);
		for (int i = 0; i < 4; i++) begin
			run(cw(fl_op[i], 0, 0, 0, 0, 0, 0));
			rchk("vs_fl", `CDM_A_FLAG, {24'h0, fl_exp[i]});
		end
		// Flag write lands while busy and must be dropped
		wr(`CDM_A_CMD, cw(CDM_IOSET, 0, 0, 0, 30, 0, 0));
		wr(`CDM_A_FLAG, 32'h00);
		run(cw(CDM_NOP, 0, 0, 0, 0, 0, 0));
		rchk("busy_drop", `CDM_A_FLAG, 32'h55);
		chk("io_set0", 32'h1f, {24'h0, cdm_mem_model_i.iom[30]});
		// Second reset with the core idle, after the last command
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk("status_rst", `CDM_A_STAT, 32'h01ff_0000);
		rchk("gpr_rst", gpr(7), 32'h0);
		test_done();
	end
endmodule // cdm_core_tb
